// ### verilog/mpqs_pkg.sv
// mpqs_pkg: shared constants for motion profile shaping and quick stop.
// assumes a 250 MHz core clock; all register times are in milliseconds.
package mpqs_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned CLK_NS = 4;
  // cycles per millisecond, derived from the clock period
  localparam int unsigned MS_CYCLES = MS_NS / CLK_NS;
  localparam logic [15:0] SCURVE_MAX_MS = 16'd1000;
  localparam logic [15:0] SCURVE_RST_MS = 16'h0000;
  localparam logic [2:0] STOP_OPT_RST = 3'h2;
  localparam logic [2:0] STOP_OPT_DB = 3'h0;
  localparam logic [2:0] STOP_OPT_DEC_OFF1 = 3'h1;
  localparam logic [2:0] STOP_OPT_DEC_OFF2 = 3'h2;
  localparam logic [2:0] STOP_OPT_DEC_ON5 = 3'h5;
  localparam logic [2:0] STOP_OPT_DEC_ON6 = 3'h6;
  localparam logic ACC_UNIT_MS = 1'b0;
  localparam logic ACC_UNIT_RATE = 1'b1;
  localparam int unsigned CW_QUICK_STOP_BIT = 2;

  // register map of the plain port
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_SCURVE = 4'h1;
  localparam logic [3:0] REG_ACCEL = 4'h2;
  localparam logic [3:0] REG_DECEL = 4'h3;
  localparam logic [3:0] REG_RATE = 4'h4;
  localparam logic [3:0] REG_QS_TC = 4'h5;
  localparam logic [3:0] REG_WARN_TC = 4'h6;
  localparam logic [3:0] REG_STATUS = 4'h7;
  localparam logic [3:0] REG_SPEED = 4'h8;
  localparam logic [3:0] REG_CTRL_ALT = 4'h9;

  // ctrl register fields
  localparam int unsigned CTRL_STOP_LSB = 0;
  localparam int unsigned CTRL_ACC_UNIT = 4;
  localparam int unsigned CTRL_POS_LSB = 5;
  localparam int unsigned CTRL_FDEC_EN = 7;
  localparam int unsigned CTRL_VARIANT = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0082;

  typedef enum logic [3:0] {
    MPQS_MODE_CSP = 4'h0, MPQS_MODE_CSV = 4'h1, MPQS_MODE_CST = 4'h2,
    MPQS_MODE_PP = 4'h3, MPQS_MODE_PV = 4'h4, MPQS_MODE_TQ = 4'h5,
    MPQS_MODE_HM = 4'h6, MPQS_MODE_PT = 4'h7, MPQS_MODE_JG = 4'h8,
    MPQS_MODE_CT = 4'h9, MPQS_MODE_SPD = 4'ha, MPQS_MODE_TRQ = 4'hb
  } mpqs_mode_t;

  typedef enum logic [2:0] {
    MPQS_ST_OP_ENABLED = 3'h0,
    MPQS_ST_QS_DECEL = 3'h1,
    MPQS_ST_QS_ACTIVE = 3'h2,
    MPQS_ST_FAULT_REACT = 3'h3,
    MPQS_ST_SW_ON_DISABLED = 3'h4,
    MPQS_ST_IDLE = 3'h5
  } mpqs_state_t;
endpackage : mpqs_pkg

// ### verilog/mpqs_ms_tick.sv
// mpqs_ms_tick: one-cycle enable every millisecond.
// assumes core_clk_i runs at the package rate.
`timescale 1ns/100ps
`default_nettype none
module mpqs_ms_tick #(
  parameter int unsigned DIV = mpqs_pkg::MS_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  output logic tick_o
);
  logic [17:0] cnt_q;
  wire cnt_end = (cnt_q == 18'(DIV - 1));
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 18'h00000;
    end else begin
      cnt_q <= cnt_end ? 18'h00000 : cnt_q + 18'h00001;
    end
  end
  assign tick_o = cnt_end;
endmodule // mpqs_ms_tick
`default_nettype wire

// ### verilog/mpqs_ms_timer.sv
// mpqs_ms_timer: loadable millisecond down counter.
// assumes tick_i is a one-cycle millisecond enable.
`timescale 1ns/100ps
`default_nettype none
module mpqs_ms_timer #(
  parameter int unsigned W = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  output logic done_o,
  output logic [W-1:0] left_o
);
  logic [W-1:0] cnt_q;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else if (load_i) begin
      cnt_q <= value_i;
    end else if (tick_i && cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end
  assign done_o = (cnt_q == '0);
  assign left_o = cnt_q;
endmodule // mpqs_ms_timer
`default_nettype wire

// ### verilog/mpqs_top.sv
// mpqs_top: S-curve profile shaping, acceleration units and quick stop.
// assumes a plain register port and drive events synchronous to core_clk_i.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - network variant smooths only when the S-curve time is nonzero.
// - smoothed acceleration phase lasts base time plus S-curve time.
// - network variant smoothing applies in profile position, profile velocity, point table, jog.
// - homing mode never smooths.
// - point table and jog delay travel-complete by the S-curve time.
// - pp, point table and jog clamp S-curve time at 1000 ms.
// - arc segment limited by acceleration and deceleration times.
// - pulse variant smooths only in speed and torque modes, nonzero time.
// - pulse variant arc limited by speed acceleration/deceleration constants.
// - rate unit ramps speed at that rate, independent of rated speed.
// - unit select 0 means milliseconds, 1 means units per second squared.
// - command unit taken from position unit: mm, inch, degree, pulse.
// - quick stop bit off decelerates per stop option, then target state.
// - forced decel disabled means dynamic brake, option ignored.
// - quick stop accepted only in Operation Enabled.
// - quick stop works in cyclic, profile, point table, jog, homing modes.
// - torque and continuous-to-torque modes brake dynamically.
// - alarm during decel enters fault reaction, quick-stop time, servo off.
// - warning during decel stays in quick stop decel, servo off after.
// - quick-stop warning uses its own time constant, then servo off.
// - command stop wins over quick stop: dynamic brake.
// - stop option 0 brake, 1/2 decel off, 5/6 decel keep on.
module mpqs_top #(
  parameter int unsigned MS_DIV = mpqs_pkg::MS_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire mpqs_pkg::mpqs_mode_t mode_i,
  input wire logic quick_stop_n_i,
  input wire logic cmd_stop_i,
  input wire logic alarm_fdec_i,
  input wire logic warn_fdec_i,
  input wire logic warn_qs_i,
  input wire logic start_i,
  input wire logic [15:0] target_speed_i,
  output logic [15:0] speed_o,
  output logic s_curve_active_o,
  output logic [15:0] accel_phase_ms_o,
  output logic [1:0] command_unit_kind_o,
  output logic dyn_brake_o,
  output logic servo_on_o,
  output logic travel_complete_output_o,
  output mpqs_pkg::mpqs_state_t state_o
);
  import mpqs_pkg::*;

  logic [31:0] ctrl_q, ctrl_alt_q;
  logic [15:0] s_curve_time_setting_q, s_curve_time_setting_alt_q;
  logic [15:0] accel_ms_q, decel_ms_q, rate_q, qs_tc_q, warn_tc_q;
  logic [31:0] rdata_q;
  mpqs_state_t state_q, state_d;
  logic [15:0] speed_q;
  logic dyn_brake_q, servo_on_q, travel_complete_output_q, travel_complete_output_wait_q, keep_on_q;
  logic qs_n_q, wqs_q;

  // register decode
  wire wr_ctrl = wr_i && addr_i == REG_CTRL;
  wire wr_scurve = wr_i && addr_i == REG_SCURVE;
  wire wr_accel = wr_i && addr_i == REG_ACCEL;
  wire wr_decel = wr_i && addr_i == REG_DECEL;
  wire wr_rate = wr_i && addr_i == REG_RATE;
  wire wr_qs_tc = wr_i && addr_i == REG_QS_TC;
  wire wr_warn_tc = wr_i && addr_i == REG_WARN_TC;
  wire wr_alt = wr_i && addr_i == REG_CTRL_ALT;

  wire [2:0] stop_method_select = ctrl_q[CTRL_STOP_LSB +: 3];
  wire accel_unit_select = ctrl_q[CTRL_ACC_UNIT];
  wire [1:0] position_unit_select = ctrl_q[CTRL_POS_LSB +: 2];
  wire forced_decel_enable = ctrl_q[CTRL_FDEC_EN];
  wire pulse_variant = ctrl_q[CTRL_VARIANT];

  // mode classes
  wire profile_position_mode = mode_i == MPQS_MODE_PP;
  wire profile_velocity_mode = mode_i == MPQS_MODE_PV;
  wire point_table_mode = mode_i == MPQS_MODE_PT;
  wire jog_mode = mode_i == MPQS_MODE_JG;
  wire homing_mode = mode_i == MPQS_MODE_HM;
  wire torque_like = mode_i == MPQS_MODE_TQ || mode_i == MPQS_MODE_CT ||
                     mode_i == MPQS_MODE_CST;
  wire qs_mode_ok = mode_i <= MPQS_MODE_CT;

  // S-curve selection and clamp
  wire clamp_mode = profile_position_mode || point_table_mode || jog_mode;
  wire [15:0] net_sc = (clamp_mode && s_curve_time_setting_q >= SCURVE_MAX_MS) ?
                       SCURVE_MAX_MS : s_curve_time_setting_q;
  wire net_mode_ok = (clamp_mode || profile_velocity_mode) && !homing_mode;
  wire pulse_mode_ok = mode_i == MPQS_MODE_SPD || mode_i == MPQS_MODE_TRQ;
  wire sc_on = pulse_variant ? (pulse_mode_ok && s_curve_time_setting_alt_q != 16'h0000)
                             : (net_mode_ok && net_sc != 16'h0000);
  wire [15:0] sc_raw = pulse_variant ? s_curve_time_setting_alt_q : net_sc;
  // arc may not outlast the shorter of the two ramp times
  wire [15:0] ramp_min = (accel_ms_q < decel_ms_q) ? accel_ms_q : decel_ms_q;
  wire [15:0] sc_eff = sc_on ? ((sc_raw > ramp_min) ? ramp_min : sc_raw) : 16'h0000;
  wire [16:0] phase_sum = {1'b0, accel_ms_q} + {1'b0, sc_eff};
  wire [15:0] phase_ms = phase_sum[16] ? 16'hffff : phase_sum[15:0];

  // millisecond timebase and timers
  logic ms_tick, travel_complete_output_done, stop_done;
  logic [15:0] stop_left;
  mpqs_ms_tick #(.DIV(MS_DIV)) u_tick (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .tick_o(ms_tick)
  );
  wire travel_complete_output_load = start_i;
  wire [15:0] travel_complete_output_val = phase_ms + ((point_table_mode || jog_mode) ? sc_eff : 16'h0000);
  mpqs_ms_timer #(.W(16)) u_travel_complete_output (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(ms_tick),
    .load_i(travel_complete_output_load),
    .value_i(travel_complete_output_val),
    .done_o(travel_complete_output_done),
    .left_o()
  );

  // quick stop decisions
  wire qs_fall = qs_n_q && !quick_stop_n_i;
  wire qs_take = qs_fall && state_q == MPQS_ST_OP_ENABLED && qs_mode_ok;
  wire opt_brake = stop_method_select == STOP_OPT_DB;
  wire opt_keep = stop_method_select == STOP_OPT_DEC_ON5 ||
                  stop_method_select == STOP_OPT_DEC_ON6;
  wire go_brake = cmd_stop_i || !forced_decel_enable || torque_like || opt_brake;
  wire in_decel = state_q == MPQS_ST_QS_DECEL;
  wire alarm_hit = in_decel && alarm_fdec_i;
  wire warn_hit = in_decel && warn_fdec_i && !alarm_fdec_i;
  // edge only: a standing warning must not reload the stop timer every cycle
  wire wqs_hit = in_decel && warn_qs_i && !wqs_q && !alarm_fdec_i && !warn_fdec_i;
  wire stop_load = (qs_take && !go_brake) || wqs_hit;
  wire [15:0] stop_val = wqs_hit ? warn_tc_q : qs_tc_q;
  mpqs_ms_timer #(.W(16)) u_stop (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(ms_tick),
    .load_i(stop_load),
    .value_i(stop_val),
    .done_o(stop_done),
    .left_o(stop_left)
  );

  // drive state transitions
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      MPQS_ST_IDLE: begin
        if (quick_stop_n_i) begin
          state_d = MPQS_ST_OP_ENABLED;
        end
      end
      MPQS_ST_OP_ENABLED: begin
        if (qs_take) begin
          state_d = go_brake ? MPQS_ST_SW_ON_DISABLED : MPQS_ST_QS_DECEL;
        end
      end
      MPQS_ST_QS_DECEL: begin
        if (alarm_hit) begin
          state_d = MPQS_ST_FAULT_REACT;
        end else if (cmd_stop_i) begin
          state_d = MPQS_ST_SW_ON_DISABLED;
        end else if (stop_done && !stop_load) begin
          state_d = keep_on_q ? MPQS_ST_QS_ACTIVE : MPQS_ST_SW_ON_DISABLED;
        end
      end
      MPQS_ST_QS_ACTIVE: begin
        if (quick_stop_n_i && keep_on_q) begin
          state_d = MPQS_ST_OP_ENABLED;
        end else if (!keep_on_q && stop_done) begin
          state_d = MPQS_ST_SW_ON_DISABLED;
        end
      end
      MPQS_ST_FAULT_REACT: begin
        if (stop_done) begin
          state_d = MPQS_ST_SW_ON_DISABLED;
        end
      end
      MPQS_ST_SW_ON_DISABLED: begin
        if (quick_stop_n_i && !cmd_stop_i) begin
          state_d = MPQS_ST_IDLE;
        end
      end
      default: state_d = MPQS_ST_SW_ON_DISABLED;
    endcase
  end

  // speed ramp: millisecond steps in time mode, per-ms rate accumulation in rate mode
  wire decel_now = in_decel || state_q == MPQS_ST_FAULT_REACT ||
                   (state_q == MPQS_ST_QS_ACTIVE && !keep_on_q);
  wire [15:0] ramp_target = decel_now ? 16'h0000 : target_speed_i;
  wire [15:0] time_step = (stop_left == 16'h0000) ? speed_q :
                          speed_q / ((stop_left == 16'h0000) ? 16'h0001 : stop_left);
  wire [15:0] ramp_step = (accel_unit_select == ACC_UNIT_RATE) ? rate_q :
                          (phase_ms == 16'h0000 ? 16'hffff : target_speed_i / phase_ms);
  wire [15:0] step = decel_now ? ((accel_unit_select == ACC_UNIT_RATE) ? rate_q : time_step)
                               : ramp_step;
  wire [15:0] gap = (speed_q > ramp_target) ? speed_q - ramp_target : ramp_target - speed_q;
  wire [15:0] mv = (gap < step) ? gap : ((step == 16'h0000) ? 16'h0001 : step);
  wire [15:0] speed_d = dyn_brake_q ? 16'h0000 : (!ms_tick ? speed_q :
                        (speed_q > ramp_target ? speed_q - mv : speed_q + mv));

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= MPQS_ST_IDLE;
      qs_n_q <= 1'b1;
      wqs_q <= 1'b0;
      speed_q <= 16'h0000;
      dyn_brake_q <= 1'b0;
      servo_on_q <= 1'b0;
      keep_on_q <= 1'b0;
    end else begin
      state_q <= state_d;
      qs_n_q <= quick_stop_n_i;
      wqs_q <= warn_qs_i;
      speed_q <= speed_d;
      if (qs_take) begin
        keep_on_q <= opt_keep && !go_brake;
      end else if (warn_hit || wqs_hit || alarm_hit) begin
        keep_on_q <= 1'b0;
      end
      dyn_brake_q <= (state_d == MPQS_ST_SW_ON_DISABLED) &&
                     (dyn_brake_q || (qs_take && go_brake) || (in_decel && cmd_stop_i));
      servo_on_q <= state_d == MPQS_ST_OP_ENABLED || state_d == MPQS_ST_QS_DECEL ||
                    state_d == MPQS_ST_QS_ACTIVE || state_d == MPQS_ST_FAULT_REACT;
    end
  end

  // travel-complete: cleared on start, set when the extended timer runs out
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      travel_complete_output_q <= 1'b1;
      travel_complete_output_wait_q <= 1'b0;
    end else if (start_i) begin
      travel_complete_output_q <= 1'b0;
      travel_complete_output_wait_q <= 1'b1;
    end else if (travel_complete_output_wait_q && travel_complete_output_done) begin
      travel_complete_output_q <= 1'b1;
      travel_complete_output_wait_q <= 1'b0;
    end
  end

  // register writes
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= CTRL_RST;
      ctrl_alt_q <= 32'h0000_0000;
      s_curve_time_setting_q <= SCURVE_RST_MS;
      s_curve_time_setting_alt_q <= SCURVE_RST_MS;
      accel_ms_q <= 16'h0000;
      decel_ms_q <= 16'h0000;
      rate_q <= 16'h0000;
      qs_tc_q <= 16'h0064;
      warn_tc_q <= 16'h0064;
    end else begin
      if (wr_ctrl) ctrl_q <= {23'h000000, wdata_i[8:0]};
      if (wr_alt) ctrl_alt_q <= wdata_i;
      if (wr_scurve) s_curve_time_setting_q <= wdata_i[15:0];
      if (wr_scurve) s_curve_time_setting_alt_q <= wdata_i[31:16];
      if (wr_accel) accel_ms_q <= wdata_i[15:0];
      if (wr_decel) decel_ms_q <= wdata_i[15:0];
      if (wr_rate) rate_q <= wdata_i[15:0];
      if (wr_qs_tc) qs_tc_q <= wdata_i[15:0];
      if (wr_warn_tc) warn_tc_q <= wdata_i[15:0];
    end
  end

  // read mux, data valid in the following cycle only
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (addr_i)
      REG_CTRL: rd_mux = ctrl_q;
      REG_SCURVE: rd_mux = {s_curve_time_setting_alt_q, s_curve_time_setting_q};
      REG_ACCEL: rd_mux = {16'h0000, accel_ms_q};
      REG_DECEL: rd_mux = {16'h0000, decel_ms_q};
      REG_RATE: rd_mux = {16'h0000, rate_q};
      REG_QS_TC: rd_mux = {16'h0000, qs_tc_q};
      REG_WARN_TC: rd_mux = {16'h0000, warn_tc_q};
      REG_STATUS: rd_mux = {23'h000000, travel_complete_output_q, servo_on_q, dyn_brake_q, sc_on, state_q,
                            position_unit_select};
      REG_SPEED: rd_mux = {16'h0000, speed_q};
      REG_CTRL_ALT: rd_mux = ctrl_alt_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rd_i ? rd_mux : 32'h0000_0000;
    end
  end

  assign rdata_o = rdata_q;
  assign speed_o = speed_q;
  assign s_curve_active_o = sc_on;
  assign accel_phase_ms_o = phase_ms;
  assign command_unit_kind_o = position_unit_select;
  assign dyn_brake_o = dyn_brake_q;
  assign servo_on_o = servo_on_q;
  assign travel_complete_output_o = travel_complete_output_q;
  assign state_o = state_q;

  // assertions
  property p_homing_no_sc;
    @(posedge core_clk_i) disable iff (!rst_n_i) homing_mode |-> !s_curve_active_o;
  endproperty
  a_homing_no_sc: assert property (p_homing_no_sc) else $error("s-curve in homing");
  property p_zero_no_sc;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (!pulse_variant && s_curve_time_setting_q == 16'h0000) |-> !s_curve_active_o;
  endproperty
  a_zero_no_sc: assert property (p_zero_no_sc) else $error("s-curve with zero time");
  property p_clamp;
    @(posedge core_clk_i) disable iff (!rst_n_i) clamp_mode |-> net_sc <= SCURVE_MAX_MS;
  endproperty
  a_clamp: assert property (p_clamp) else $error("s-curve time not clamped");
  property p_phase;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      !phase_sum[16] |-> accel_phase_ms_o == accel_ms_q + sc_eff;
  endproperty
  a_phase: assert property (p_phase) else $error("phase length wrong");
  property p_only_op_en;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      $rose(state_q == MPQS_ST_QS_DECEL) |-> $past(state_q) == MPQS_ST_OP_ENABLED;
  endproperty
  a_only_op_en: assert property (p_only_op_en) else $error("quick stop outside op enabled");
  property p_brake_cmd;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (qs_take && cmd_stop_i) |=> (dyn_brake_o && state_q == MPQS_ST_SW_ON_DISABLED);
  endproperty
  a_brake_cmd: assert property (p_brake_cmd) else $error("command stop not braked");
  property p_fdec_off;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (qs_take && !forced_decel_enable) |=> dyn_brake_o;
  endproperty
  a_fdec_off: assert property (p_fdec_off) else $error("no brake with decel off");
  property p_alarm;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      alarm_hit |=> (state_q == MPQS_ST_FAULT_REACT && servo_on_o);
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm did not enter fault reaction");
  property p_fault_off;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (state_q == MPQS_ST_FAULT_REACT && stop_done) |=> !servo_on_o;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("servo on after fault stop");
endmodule // mpqs_top
`default_nettype wire

// ### verification/mpqs_ctrl_model.sv
// mpqs_ctrl_model: motion controller on the far side of the profile block.
// assumes the bench calls its tasks; every change lands just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module mpqs_ctrl_model (
  input wire logic core_clk_i,
  output mpqs_pkg::mpqs_mode_t mode_o,
  output logic quick_stop_n_o,
  output logic cmd_stop_o,
  output logic alarm_fdec_o,
  output logic warn_fdec_o,
  output logic warn_qs_o,
  output logic start_o,
  output logic [15:0] target_speed_o
);
  import mpqs_pkg::*;

  // quick stop held on until the bench releases it, so the drive idles safely
  initial begin
    mode_o = MPQS_MODE_PP;
    quick_stop_n_o = 1'b0;
    cmd_stop_o = 1'b0;
    alarm_fdec_o = 1'b0;
    warn_fdec_o = 1'b0;
    warn_qs_o = 1'b0;
    start_o = 1'b0;
    target_speed_o = 16'h0400;
  end

  task automatic drive(input mpqs_mode_t m, input logic qs_n, input logic cs);
    @(posedge core_clk_i);
    mode_o <= m;
    quick_stop_n_o <= qs_n;
    cmd_stop_o <= cs;
  endtask

  task automatic events(input logic al, input logic wf, input logic wq);
    @(posedge core_clk_i);
    alarm_fdec_o <= al;
    warn_fdec_o <= wf;
    warn_qs_o <= wq;
  endtask

  task automatic pulse_start();
    @(posedge core_clk_i);
    start_o <= 1'b1;
    @(posedge core_clk_i);
    start_o <= 1'b0;
  endtask
endmodule // mpqs_ctrl_model
`default_nettype wire

// ### verification/tb.sv
// tb: self-checking bench for mpqs_top with a controller model.
// assumes a 250 MHz core clock and the plain register port of the package map.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import mpqs_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  mpqs_mode_t mode_i;
  logic quick_stop_n_i, cmd_stop_i, alarm_fdec_i, warn_fdec_i, warn_qs_i, start_i;
  logic [15:0] target_speed_i, speed_o, accel_phase_ms_o;
  logic s_curve_active_o, dyn_brake_o, servo_on_o, travel_complete_output_o;
  logic [1:0] command_unit_kind_o;
  mpqs_state_t state_o;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;

  initial begin
    forever #2 core_clk_i = ~core_clk_i;
  end

  mpqs_ctrl_model mpqs_ctrl_model_inst (.core_clk_i(core_clk_i), .mode_o(mode_i),
    .quick_stop_n_o(quick_stop_n_i), .cmd_stop_o(cmd_stop_i), .alarm_fdec_o(alarm_fdec_i),
    .warn_fdec_o(warn_fdec_i), .warn_qs_o(warn_qs_i), .start_o(start_i),
    .target_speed_o(target_speed_i));

  // short millisecond so the stop and travel timers run out within the run
  mpqs_top #(.MS_DIV(4))
  mpqs_top_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .mode_i(mode_i),
    .quick_stop_n_i(quick_stop_n_i), .cmd_stop_i(cmd_stop_i), .alarm_fdec_i(alarm_fdec_i),
    .warn_fdec_i(warn_fdec_i), .warn_qs_i(warn_qs_i), .start_i(start_i),
    .target_speed_i(target_speed_i), .speed_o(speed_o), .s_curve_active_o(s_curve_active_o),
    .accel_phase_ms_o(accel_phase_ms_o), .command_unit_kind_o(command_unit_kind_o),
    .dyn_brake_o(dyn_brake_o), .servo_on_o(servo_on_o),
    .travel_complete_output_o(travel_complete_output_o), .state_o(state_o));

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // the run is under a thousand cycles; a hang is cut off well beyond that
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic do_reset();
    @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
  endtask

  // release quick stop and wait for operation enabled, then request the stop
  task automatic enter_stop(input logic [31:0] ctl, input mpqs_mode_t m, input logic cs);
    do_reset();
    reg_wr(REG_CTRL, ctl);
    mpqs_ctrl_model_inst.drive(m, 1'b1, cs);
    for (int i = 0; i < 8 && state_o !== MPQS_ST_OP_ENABLED; i++) @(posedge core_clk_i);
    mpqs_ctrl_model_inst.drive(m, 1'b0, cs);
    @(posedge core_clk_i);
    #1;
  endtask

  task automatic test_regs();
    logic [31:0] d;
    do_reset();
    reg_rd(REG_CTRL, d);
    check("ctrl reset", d, CTRL_RST);
    reg_rd(REG_QS_TC, d);
    check("qs time reset", d, 32'h0000_0064);
    reg_rd(REG_SCURVE, d);
    check("s-curve reset", d, 32'h0000_0000);
    reg_rd(4'ha, d);
    check("unmapped read", d, 32'h0000_0000);
    // quick stop bit never released: request must not be accepted outside op enabled
    reg_rd(REG_STATUS, d);
    check("status idle", d, 32'h0000_0114);
    reg_wr(REG_CTRL, 32'h0000_0085);
    reg_rd(REG_CTRL, d);
    check("ctrl readback", d, 32'h0000_0085);
    $display("test_regs done");
  endtask

  task automatic test_scurve();
    logic [31:0] ctl [10] = '{32'h82, 32'h82, 32'h82, 32'h82, 32'h82, 32'h82, 32'h82,
      32'h182, 32'h182, 32'h182};
    logic [31:0] sc [10] = '{32'h12c, 32'h0, 32'h12c, 32'h5dc, 32'h5dc, 32'h12c, 32'h12c,
      32'h01f4_0000, 32'h01f4_0000, 32'h0};
    logic [31:0] dec [10] = '{32'hbb8, 32'hbb8, 32'hbb8, 32'hbb8, 32'hbb8, 32'hbb8,
      32'hc8, 32'hbb8, 32'hbb8, 32'hbb8};
    mpqs_mode_t md [10] = '{MPQS_MODE_PP, MPQS_MODE_PP, MPQS_MODE_HM, MPQS_MODE_PT,
      MPQS_MODE_JG, MPQS_MODE_PV, MPQS_MODE_PP, MPQS_MODE_SPD, MPQS_MODE_PP, MPQS_MODE_TRQ};
    logic act [10] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    logic [15:0] ms [10] = '{16'd3300, 16'd3000, 16'd3000, 16'd4000, 16'd4000, 16'd3300,
      16'd3200, 16'd3500, 16'd3000, 16'd3000};
    do_reset();
    reg_wr(REG_ACCEL, 32'hbb8);
    for (int i = 0; i < 10; i++) begin
      reg_wr(REG_CTRL, ctl[i]);
      reg_wr(REG_SCURVE, sc[i]);
      reg_wr(REG_DECEL, dec[i]);
      mpqs_ctrl_model_inst.drive(md[i], 1'b0, 1'b0);
      @(posedge core_clk_i);
      #1;
      check("s-curve active", {31'h0, s_curve_active_o}, {31'h0, act[i]});
      check("accel phase ms", {16'h0, accel_phase_ms_o}, {16'h0, ms[i]});
    end
    $display("test_scurve done");
  endtask

  task automatic test_units();
    logic [15:0] s;
    do_reset();
    for (int k = 0; k < 4; k++) begin
      reg_wr(REG_CTRL, 32'h92 | (k << 5));
      #1 check("command unit", {30'h0, command_unit_kind_o}, k);
    end
    // rate unit stays selected; any four cycles hold exactly one tick
    reg_wr(REG_RATE, 32'h10);
    #1 s = speed_o;
    repeat (4) @(posedge core_clk_i);
    #1 check("rate ramp", {16'h0, speed_o}, {16'h0, s + 16'h10});
    $display("test_units done");
  endtask

  task automatic test_qs();
    logic [31:0] ctl [10] = '{32'h80, 32'h81, 32'h82, 32'h85, 32'h86, 32'h02, 32'h82,
      32'h82, 32'h82, 32'h82};
    mpqs_mode_t md [10] = '{MPQS_MODE_PP, MPQS_MODE_CSP, MPQS_MODE_PV, MPQS_MODE_HM,
      MPQS_MODE_JG, MPQS_MODE_PP, MPQS_MODE_TQ, MPQS_MODE_CT, MPQS_MODE_PP, MPQS_MODE_PT};
    logic cs [10] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    logic brk [10] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 10; i++) begin
      enter_stop(ctl[i], md[i], cs[i]);
      check("stop state", 32'(state_o),
        brk[i] ? 32'(MPQS_ST_SW_ON_DISABLED) : 32'(MPQS_ST_QS_DECEL));
      check("dyn brake", {31'h0, dyn_brake_o}, {31'h0, brk[i]});
      check("servo on", {31'h0, servo_on_o}, {31'h0, !brk[i]});
    end
    $display("test_qs done");
  endtask

  task automatic test_events();
    enter_stop(32'h82, MPQS_MODE_PP, 1'b0);
    mpqs_ctrl_model_inst.events(1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 8 && state_o !== MPQS_ST_FAULT_REACT; i++) @(posedge core_clk_i);
    #1 check("alarm state", 32'(state_o), 32'(MPQS_ST_FAULT_REACT));
    repeat (420) @(posedge core_clk_i);
    #1 check("fault servo off", {31'h0, servo_on_o}, 32'h0);
    mpqs_ctrl_model_inst.events(1'b0, 1'b0, 1'b0);
    enter_stop(32'h82, MPQS_MODE_PP, 1'b0);
    mpqs_ctrl_model_inst.events(1'b0, 1'b1, 1'b0);
    repeat (4) @(posedge core_clk_i);
    #1 check("warn no fault", {31'h0, state_o == MPQS_ST_FAULT_REACT}, 32'h0);
    mpqs_ctrl_model_inst.events(1'b0, 1'b0, 1'b0);
    enter_stop(32'h82, MPQS_MODE_PP, 1'b0);
    reg_wr(REG_WARN_TC, 32'h2);
    mpqs_ctrl_model_inst.events(1'b0, 1'b0, 1'b1);
    repeat (20) @(posedge core_clk_i);
    #1 check("warn time stop", 32'(state_o), 32'(MPQS_ST_SW_ON_DISABLED));
    $display("test_events done");
  endtask

  task automatic test_travel();
    do_reset();
    #1 check("travel at reset", {31'h0, travel_complete_output_o}, 32'h1);
    reg_wr(REG_ACCEL, 32'ha);
    reg_wr(REG_DECEL, 32'ha);
    reg_wr(REG_SCURVE, 32'h5);
    mpqs_ctrl_model_inst.drive(MPQS_MODE_PT, 1'b1, 1'b0);
    mpqs_ctrl_model_inst.pulse_start();
    #1 check("travel after start", {31'h0, travel_complete_output_o}, 32'h0);
    // 10 + 5 + 5 ms of 4 cycles: rises 78 to 81 cycles after the start edge
    repeat (76) @(posedge core_clk_i);
    #1 check("travel held", {31'h0, travel_complete_output_o}, 32'h0);
    repeat (5) @(posedge core_clk_i);
    #1 check("travel done", {31'h0, travel_complete_output_o}, 32'h1);
    $display("test_travel done");
  endtask

  initial begin
    test_regs();
    test_scurve();
    test_units();
    test_qs();
    test_events();
    test_travel();
    end_sim();
  end
endmodule // tb
`default_nettype wire
